/* File: design/pef_ecc_fault.sv */
// Program fetch ECC checker with fault address capture and Wishbone regs.
// Assumes flash word, fetch and SRAM error inputs are on SYS_CLK.
`timescale 1ns/100ps
`include "pef_defines.svh"

// How it works
// - SRAM ECC error loads its 16-bit address into read-only fault regs.
// - While the SRAM error flag is set, the captured address holds.
// - Low flash byte is the instruction, high byte its check bits.
// - Flash 15:12 checks data 7:4; flash 11:8 checks data 3:0.
// - Each nibble corrects one bit and detects two, independently.
// - Checking sits inline on every fetch, never stalling it.
// - Correctable fetch gives corrected byte; irq only when enabled.
// - Uncorrectable fetch raises a software reset when the action bit is set, else its irq when enabled.
// - Any program ECC event latches the fetch address.
// - Program fault address is read-only and holds the latest error.
// - Correctable flag sets regardless of enable; software clears it.
// - Configuration resets to 0x80, read correction enabled.
// - SRAM uncorrectable error captures address and sets its status bit; it interrupts the CPU only when its mask bit is set.
module pef_ecc_fault (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [17:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        FETCH_VALID,
  input  wire logic [15:0] FETCH_ADDR,
  input  wire logic [15:0] FLASH_WORD,
  input  wire logic        FC_READ,
  input  wire logic        SRAM_ERR,
  input  wire logic [15:0] SRAM_ERR_ADDR,
  output logic      [7:0]  FETCH_DATA,
  output logic             FETCH_DATA_VALID,
  output logic      [15:0] FC_DATA,
  output logic             FC_DATA_VALID,
  output logic             SW_RESET,
  output logic             IRQ
);

  pef_pkg::pef_state_s s_q;
  pef_pkg::pef_state_s s_d;

  // Nibble decode: returns {double, single, corrected data}
  function automatic logic [5:0] pef_fix(
    input logic [3:0] d,
    input logic [3:0] c
  );
    logic [2:0] syn;
    logic       par;
    logic [3:0] flip;
    syn[0] = c[0] ^ d[0] ^ d[1] ^ d[3];
    syn[1] = c[1] ^ d[0] ^ d[2] ^ d[3];
    syn[2] = c[2] ^ d[1] ^ d[2] ^ d[3];
    par    = ^{d, c};
    // Hamming positions 3,5,6,7 hold the data bits
    case (syn)
      3'h3:    flip = 4'h1;
      3'h5:    flip = 4'h2;
      3'h6:    flip = 4'h4;
      3'h7:    flip = 4'h8;
      default: flip = 4'h0;
    endcase
    // Odd parity means one flip; even with syndrome means two
    if (par) begin
      pef_fix = {1'b0, 1'b1, d ^ flip};
    end else begin
      pef_fix = {(syn != 3'h0), 1'b0, d};
    end
  endfunction : pef_fix

  logic [7:0] fix_byte;
  logic [1:0] nib_sgl;
  logic [1:0] nib_dbl;

  // One decoder per nibble, check code in the high byte
  for (genvar n = 0; n < 2; n++) begin : g_nib
    assign {nib_dbl[n], nib_sgl[n], fix_byte[4*n +: 4]} =
      pef_fix(FLASH_WORD[4*n +: 4], FLASH_WORD[8 + 4*n +: 4]);
  end

  logic       ev_unc;
  logic       ev_cor;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [15:0] idx;
  logic [7:0]  wdat;
  logic [7:0]  cfg_rd;
  logic [7:0]  cfg_rst;

  // Register map, byte address is four times the index:
  //   configuration    read-correct, two enables, two sticky flags
  //   program fault    low and high halves, read-only
  //   SRAM fault       low and high halves, read-only
  //   status           corr, uncorr, SRAM; cleared by its own read
  //   mask             same layout as status, gates the IRQ level
  //   action           bit 0 turns an uncorrectable fetch into a reset
  // Halves of a fault address are not locked against each other, so
  // software reading low then high may see two different errors.

  // Configuration reset image, taken apart field by field below
  assign cfg_rst = `PEF_CFG_RST;

  // Fetch events; a double in either nibble outranks a single
  assign ev_unc = FETCH_VALID & (|nib_dbl);
  assign ev_cor = FETCH_VALID & (|nib_sgl) & ~(|nib_dbl);

  // Classic Wishbone decode, one access per ack
  assign acc  = WB_CYC_I & WB_STB_I & ~s_q.ack;
  assign wr   = acc & WB_WE_I & WB_SEL_I[0];
  assign rd   = acc & ~WB_WE_I;
  assign idx  = WB_ADR_I[17:2];
  assign wdat = WB_DAT_I[7:0];

  // Configuration read image, reserved bits zero
  always_comb begin
    cfg_rd = 8'h00;
    cfg_rd[`PEF_CFG_CCEN] = s_q.ccen;
    cfg_rd[`PEF_CFG_UIEN] = s_q.uien;
    cfg_rd[`PEF_CFG_CIEN] = s_q.cien;
    cfg_rd[`PEF_CFG_UFLG] = s_q.uflg;
    cfg_rd[`PEF_CFG_CFLG] = s_q.cflg;
  end

  // Next state of everything
  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.swrst = 1'b0;

    // Read data, unmapped addresses read zero
    if (rd) begin
      case (idx)
        `PEF_IDX_CFG:  s_d.rdata = cfg_rd;
        `PEF_IDX_PADL: s_d.rdata = s_q.flash_fault_address[7:0];
        `PEF_IDX_PADH: s_d.rdata = s_q.flash_fault_address[15:8];
        `PEF_IDX_DADL: s_d.rdata = s_q.sram_fault_address[7:0];
        `PEF_IDX_DADH: s_d.rdata = s_q.sram_fault_address[15:8];
        `PEF_IDX_STAT: s_d.rdata = {5'h00, s_q.irq_stat};
        `PEF_IDX_MASK: s_d.rdata = {5'h00, s_q.irq_mask};
        `PEF_IDX_ACT:  s_d.rdata = {7'h00, s_q.act_rst};
        default:       s_d.rdata = 8'h00;
      endcase
    end

    // Register writes; fault address registers ignore writes
    if (wr) begin
      case (idx)
        `PEF_IDX_CFG: begin
          s_d.ccen = wdat[`PEF_CFG_CCEN];
          s_d.uien = wdat[`PEF_CFG_UIEN];
          s_d.cien = wdat[`PEF_CFG_CIEN];
          s_d.uflg = wdat[`PEF_CFG_UFLG];
          s_d.cflg = wdat[`PEF_CFG_CFLG];
        end
        `PEF_IDX_MASK: s_d.irq_mask = wdat[`PEF_ST_W-1:0];
        `PEF_IDX_ACT:  s_d.act_rst  = wdat[`PEF_ACT_RST];
        default: begin
        end
      endcase
    end

    // Status register clears on read; events below win
    if (rd && idx == `PEF_IDX_STAT) begin
      s_d.irq_stat = '0;
    end

    // Corrected byte goes out one cycle after every fetch
    s_d.fetch_vld = FETCH_VALID;
    if (FETCH_VALID) begin
      s_d.fetch_data = fix_byte;
    end

    // Controller read: corrected low byte or raw word
    s_d.fc_vld = FC_READ;
    if (FC_READ) begin
      s_d.fc_data = s_q.ccen ? {8'h00, fix_byte}
                             : FLASH_WORD;
    end

    // Correctable fetch: flag always, interrupt if enabled
    if (ev_cor) begin
      s_d.cflg = 1'b1;
      if (s_q.cien) begin
        s_d.irq_stat[`PEF_ST_CORR] = 1'b1;
      end
    end

    // Uncorrectable fetch: flag always, then reset or interrupt
    if (ev_unc) begin
      s_d.uflg = 1'b1;
      if (s_q.act_rst) begin
        s_d.swrst = 1'b1;
      end else if (s_q.uien) begin
        s_d.irq_stat[`PEF_ST_UNCORR] = 1'b1;
      end
    end

    // Latest program fault address, no hold
    if (ev_cor || ev_unc) begin
      s_d.flash_fault_address = FETCH_ADDR;
    end

    // SRAM error: capture only when its flag is clear
    if (SRAM_ERR) begin
      s_d.irq_stat[`PEF_ST_SRAM] = 1'b1;
      if (!s_q.irq_stat[`PEF_ST_SRAM]) begin
        s_d.sram_fault_address = SRAM_ERR_ADDR;
      end
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_q <= '0;
      // Fields of the configuration reset image, no shifting tricks
      s_q.ccen <= cfg_rst[`PEF_CFG_CCEN];
      s_q.uien <= cfg_rst[`PEF_CFG_UIEN];
      s_q.cien <= cfg_rst[`PEF_CFG_CIEN];
      s_q.uflg <= cfg_rst[`PEF_CFG_UFLG];
      s_q.cflg <= cfg_rst[`PEF_CFG_CFLG];
      // Fault addresses start at their documented reset pattern
      s_q.flash_fault_address <= `PEF_ADDR_RST;
      s_q.sram_fault_address  <= `PEF_ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign WB_ACK_O         = s_q.ack;
  assign WB_DAT_O         = {24'h000000, s_q.rdata};
  assign FETCH_DATA       = s_q.fetch_data;
  assign FETCH_DATA_VALID = s_q.fetch_vld;
  assign FC_DATA          = s_q.fc_data;
  assign FC_DATA_VALID    = s_q.fc_vld;
  assign SW_RESET         = s_q.swrst;
  // Level interrupt while any unmasked sticky bit is set
  assign IRQ              = |(s_q.irq_stat & s_q.irq_mask);

endmodule : pef_ecc_fault

/* File: design/pef_defines.svh */
// Register indices, field positions and reset values of the ECC fault block.
// Assumes a byte address of four times the index on the Wishbone bus.
`ifndef PEF_DEFINES_SVH
`define PEF_DEFINES_SVH

// Register indices (byte address is index times four)
`define PEF_IDX_CFG     16'hA00D
`define PEF_IDX_PADL    16'hA00E
`define PEF_IDX_PADH    16'hA00F
`define PEF_IDX_DADL    16'hA02E
`define PEF_IDX_DADH    16'hA02F
`define PEF_IDX_STAT    16'hA030
`define PEF_IDX_MASK    16'hA031
`define PEF_IDX_ACT     16'hA032

// Configuration register fields
`define PEF_CFG_CCEN    7
`define PEF_CFG_UIEN    5
`define PEF_CFG_CIEN    4
`define PEF_CFG_UFLG    1
`define PEF_CFG_CFLG    0

// Interrupt status and mask fields
`define PEF_ST_CORR     0
`define PEF_ST_UNCORR   1
`define PEF_ST_SRAM     2
`define PEF_ST_W        3

// Fault action register field
`define PEF_ACT_RST     0

// Reset values
`define PEF_CFG_RST     8'h80
`define PEF_ADDR_RST    16'h8000

`endif

/* File: design/pef_pkg.sv */
// Types shared by the ECC fault block.
// Assumes pef_defines.svh is compiled first.
`include "pef_defines.svh"

package pef_pkg;

  // Whole state of the block, registered in one process
  typedef struct packed {
    logic                 ack;
    logic [7:0]           rdata;
    logic                 ccen;
    logic                 uien;
    logic                 cien;
    logic                 uflg;
    logic                 cflg;
    logic [15:0]          flash_fault_address;
    logic [15:0]          sram_fault_address;
    logic [`PEF_ST_W-1:0] irq_stat;
    logic [`PEF_ST_W-1:0] irq_mask;
    logic                 act_rst;
    logic [7:0]           fetch_data;
    logic                 fetch_vld;
    logic [15:0]          fc_data;
    logic                 fc_vld;
    logic                 swrst;
  } pef_state_s;

endpackage : pef_pkg

/* File: tb/pef_ecc_fault_props.sv */
// Port checks for the ECC fault block.
// Assumes one SYS_CLK domain and a synchronous RESET.
`timescale 1ns/100ps
module pef_ecc_fault_props (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic FETCH_VALID,
  input wire logic FETCH_DATA_VALID,
  input wire logic FC_READ,
  input wire logic FC_DATA_VALID,
  input wire logic SW_RESET,
  input wire logic IRQ
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Bus answers exactly one cycle after a taken request
  ack_follows_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack late");
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held");
  ack_has_cause_a: assert property (WB_ACK_O |-> $past(WB_STB_I))
    else $error("ack without request");
  // Inline check: result one cycle after every fetch, never stalled
  fetch_in_step_a: assert property (FETCH_VALID |=> FETCH_DATA_VALID)
    else $error("fetch result late");
  fetch_no_extra_a: assert property (!FETCH_VALID |=> !FETCH_DATA_VALID)
    else $error("fetch result unasked");
  fc_in_step_a: assert property (FC_READ |=> FC_DATA_VALID)
    else $error("controller read late");
  fc_no_extra_a: assert property (!FC_READ |=> !FC_DATA_VALID)
    else $error("controller data unasked");
  // A reset request only ever follows a fetch, and only for a cycle
  swrst_cause_a: assert property (SW_RESET |-> $past(FETCH_VALID))
    else $error("reset request without fetch");
  swrst_pulse_a: assert property (SW_RESET |=> !SW_RESET)
    else $error("reset request held");
  fetch_seen_c: cover property (FETCH_VALID ##1 FETCH_DATA_VALID);
  swrst_seen_c: cover property (SW_RESET);
  irq_seen_c: cover property ($rose(IRQ));
endmodule : pef_ecc_fault_props

bind pef_ecc_fault pef_ecc_fault_props pef_ecc_fault_props_i (.*);

/* File: tb/pef_flash_model.sv */
// Flash array model: gives the stored word of one instruction byte.
// Assumes req is high while a fetch or controller read is pending.
`timescale 1ns/100ps
module pef_flash_model (
  input  wire logic        req,
  input  wire logic [7:0]  d,
  input  wire logic [15:0] flip,
  output logic      [15:0] word
);
  // Nibble check code
  function automatic logic [3:0] enc(input logic [3:0] n);
    return {n[0]^n[1]^n[2], n[1]^n[2]^n[3], n[0]^n[2]^n[3], n[0]^n[1]^n[3]};
  endfunction : enc
  // Inverse when idle: a late sample decodes clean, but to the inverted byte
  assign word = (req ? 16'h0000 : 16'hFFFF) ^ flip
    ^ {enc(d[7:4]), enc(d[3:0]), d};
endmodule : pef_flash_model

/* File: tb/pef_ecc_fault_tb.sv */
// Self-checking bench for the ECC fault block.
// Assumes the design and flash model are compiled before it.
`timescale 1ns/100ps
`include "pef_defines.svh"
module pef_ecc_fault_tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, fv = 0, fcr = 0;
  logic serr = 0, ack, fdv, fcdv, swr, irq;
  logic [17:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [15:0] fa = '0, sa = '0, mf = '0, fw, fcd, seen;
  logic [7:0]  md = '0, fd;
  int miscompares = 0, n_checks = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  pef_ecc_fault pef_ecc_fault_i (.SYS_CLK(clk), .RESET(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FETCH_VALID(fv),
    .FETCH_ADDR(fa), .FLASH_WORD(fw), .FC_READ(fcr), .SRAM_ERR(serr),
    .SRAM_ERR_ADDR(sa), .FETCH_DATA(fd), .FETCH_DATA_VALID(fdv),
    .FC_DATA(fcd), .FC_DATA_VALID(fcdv), .SW_RESET(swr), .IRQ(irq));
  pef_flash_model pef_flash_model_i (.req(fv | fcr), .d(md), .flip(mf),
    .word(fw));
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Classic single cycle; waits for ack under a bound
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 2'b00, 24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    {cyc, stb, we} <= 3'b000;
    if (ack !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rchk
  // Fetch (f=1) or controller read; results sampled one cycle later
  task automatic fetch(input logic f, input logic [15:0] a,
                       input logic [7:0] d, input logic [15:0] m);
    @(posedge clk);
    {fv, fcr, fa, md, mf} <= {f, !f, a, d, m};
    @(posedge clk);
    seen = fw;
    {fv, fcr} <= 2'b00;
    #1;
  endtask : fetch
  task automatic sram_err(input logic [15:0] a);
    @(posedge clk);
    {serr, sa} <= {1'b1, a};
    @(posedge clk);
    serr <= 1'b0;
    #1;
  endtask : sram_err
  task automatic t_reset;
    rchk(`PEF_IDX_CFG, 8'h80);
    rchk(`PEF_IDX_DADH, 8'h80);
    wr(`PEF_IDX_PADL, 8'hFF);
    rchk(`PEF_IDX_PADL, 8'h00);
    rchk(16'hA040, 8'h00);
  endtask : t_reset
  task automatic t_corr;
    wr(`PEF_IDX_CFG, 8'h90);
    wr(`PEF_IDX_MASK, 8'h07);
    fetch(1'b1, 16'h1234, 8'h5A, 16'h0040);
    chk(fd, 8'h5A);
    chk(fdv, 1'b1);
    chk(irq, 1'b1);
    rchk(`PEF_IDX_CFG, 8'h91);
    rchk(`PEF_IDX_PADH, 8'h12);
    rchk(`PEF_IDX_STAT, 8'h01);
    wr(`PEF_IDX_CFG, 8'h80);
    fetch(1'b1, 16'h2222, 8'h0F, 16'h1000);
    chk(irq, 1'b0);
    rchk(`PEF_IDX_CFG, 8'h81);
    rchk(`PEF_IDX_PADL, 8'h22);
  endtask : t_corr
  task automatic t_uncorr;
    wr(`PEF_IDX_CFG, 8'hA0);
    fetch(1'b1, 16'h4321, 8'hC3, 16'h0011);
    chk(fd, 8'hC3);
    fetch(1'b1, 16'h5678, 8'hC3, 16'h0003);
    chk({swr, irq}, 2'b01);
    rchk(`PEF_IDX_CFG, 8'hA3);
    rchk(`PEF_IDX_PADL, 8'h78);
    rchk(`PEF_IDX_STAT, 8'h02);
    wr(`PEF_IDX_ACT, 8'h01);
    fetch(1'b1, 16'h9ABC, 8'h11, 16'h0030);
    chk({swr, irq}, 2'b10);
    wr(`PEF_IDX_ACT, 8'h00);
  endtask : t_uncorr
  task automatic t_fc;
    fetch(1'b0, 16'h0100, 8'h3C, 16'h0004);
    chk(fcd, 16'h003C);
    chk(fcdv, 1'b1);
    wr(`PEF_IDX_CFG, 8'h00);
    fetch(1'b0, 16'h0101, 8'h3C, 16'h0104);
    chk(fcd, seen);
  endtask : t_fc
  task automatic t_sram;
    sram_err(16'hBEEF);
    chk(irq, 1'b1);
    sram_err(16'h1111);
    rchk(`PEF_IDX_DADL, 8'hEF);
    rchk(`PEF_IDX_STAT, 8'h04);
    sram_err(16'h1111);
    rchk(`PEF_IDX_DADH, 8'h11);
  endtask : t_sram
  // Reset for 16 cycles, then each scenario in turn
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_corr();
    t_uncorr();
    t_fc();
    t_sram();
    results();
  end
endmodule : pef_ecc_fault_tb
